// ### hw/fpd_params.svh
// constants for the floating point divide sequencer and its host
`ifndef FPD_PARAMS_SVH
`define FPD_PARAMS_SVH

// stage indices and count
`define STG_PIPE1 0
`define STG_PIPE2 1
`define STG_PIPE3 2
`define STG_OUT 3
`define STG_LAST 3
`define STG_NUM 4

// divide and multiply stage timing multipliers
`define DIV_S2_SINGLE 8'h09
`define DIV_S2_DOUBLE 8'h12
`define DIV_S3_MULT 8'h02
`define DIV_EXTRA_SINGLE 8'h01
`define DIV_EXTRA_DOUBLE 8'h02
`define MUL_S2_WIDE 8'h02
`define ONE_CYCLE 8'h01

// host spacing after a divide ready pulse
`define GAP_FAST 3'h2
`define GAP_SLOW 3'h4
`define GAP_SHORT_OFF 3'h3

// number formats
`define BIAS_S 14'sh007F
`define BIAS_D 14'sh03FF
`define EMAX_S 14'sh00FF
`define EMAX_D 14'sh07FF
`define EXP_ONES_S 11'h0FF
`define EXP_ONES_D 11'h7FF
`define FRAC_D_W 52
`define SIGN_D 63
`define SIGN_S 31
`define PAD_S 29'h0
`define NAN_S 64'h0000_0000_7FFF_FFFF
`define NAN_D 64'h7FFF_FFFF_FFFF_FFFF
`define ALU_OFF 2'h0

`endif

// ### hw/fpd_pkg.sv
// types shared by the divide sequencer, its host and the classifier
package fpd_pkg;

    typedef enum logic [1:0] {
        FN_DIV = 2'h0,
        FN_MUL = 2'h1,
        FN_ALU = 2'h2
    } func_t;

    typedef enum logic [4:0] {
        NUM_ZERO = 5'h01,
        NUM_DENORMAL = 5'h02,
        NUM_NORMAL = 5'h04,
        NUM_INFINITY = 5'h08,
        NUM_NAN = 5'h10
    } num_class_t;

    typedef enum logic [3:0] {
        H_IDLE = 4'h1,
        H_LO = 4'h2,
        H_WAIT_RDY = 4'h4,
        H_GAP = 4'h8
    } host_state_t;

    typedef struct packed {
        func_t func;
        logic dbl;
        logic [63:0] a;
        logic [63:0] b;
        num_class_t ca;
        num_class_t cb;
        logic sa;
        logic sb;
        logic signed [13:0] ea;
        logic signed [13:0] eb;
        logic [52:0] ma;
        logic [52:0] mb;
    } op_t;

endpackage : fpd_pkg

// ### hw/fpd_if.sv
// link between the host sequencer and the divide sequencer
`timescale 1ns/1ps
interface fpd_if;
    logic load;
    fpd_pkg::func_t func;
    logic dbl;
    logic [31:0] a_word;
    logic [31:0] b_word;
    logic [1:0] pipe_adv;
    logic [1:0] pp_adv;
    logic s2_uniform;
    logic can_load;
    logic ready;
    logic result_valid;
    logic [63:0] result;

    modport dev(input load, func, dbl, a_word, b_word, pipe_adv, pp_adv,
                s2_uniform, output can_load, ready, result_valid, result);
    modport host(output load, func, dbl, a_word, b_word, pipe_adv, pp_adv,
                 s2_uniform, input can_load, ready, result_valid, result);
endinterface : fpd_if

// ### hw/fp_classify.sv
// operand classifier and denormal wrapper
`timescale 1ns/1ps
`include "fpd_params.svh"
module fp_classify (
    input wire logic [63:0] i_word,
    input wire logic i_dbl,
    output fpd_pkg::num_class_t o_class,
    output logic o_sign,
    output logic signed [13:0] o_exp,
    output logic [52:0] o_mant
);
    import fpd_pkg::*;

    logic [10:0] e;
    logic [51:0] f;
    logic [5:0] shifts;

    always_comb begin
        o_sign = i_dbl ? i_word[`SIGN_D] : i_word[`SIGN_S];
        e = i_dbl ? i_word[62:52] : {3'h0, i_word[30:23]};
        f = i_dbl ? i_word[51:0] : {i_word[22:0], `PAD_S};
        // highest set fraction bit decides the wrap shift
        shifts = 6'h00;
        for (int i = 0; i < `FRAC_D_W; i++) begin
            if (f[i]) begin
                shifts = 6'(`FRAC_D_W - i);
            end
        end
        o_mant = {1'b1, f};
        o_exp = $signed({3'h0, e});
        o_class = NUM_NORMAL;
        if (e == (i_dbl ? `EXP_ONES_D : `EXP_ONES_S)) begin
            o_class = (f == 52'h0) ? NUM_INFINITY : NUM_NAN;
        end else if (e == 11'h000) begin
            if (f == 52'h0) begin
                o_class = NUM_ZERO;
                o_mant = 53'h0;
            end else begin
                o_class = NUM_DENORMAL;
                o_mant = 53'({1'b0, f} << shifts);
                o_exp = 14'sh0001 - $signed({8'h00, shifts});
            end
        end
    end

endmodule : fp_classify

// ### hw/fpd_device.sv
// floating point divide and multiply sequencer, device end of the link
// Behaviour
// - single divide: 1 P, 9 A, 2 P
// - double divide: 1 P, 18 A, 2 P
// - terms map to pipe stages one to three
// - divide ignores the stage-2 uniform bit
// - ready pulses one cycle entering stage 3
// - fast grade: next op two cycles after ready
// - slow grade: next op four cycles after ready
// - host keys next op from ready pulse
// - new load mid divide: new op wins
// - quotient is B divided by A
// - 64-bit ALU op: two input beats, P=00 (host forces P=00 on fast grade only)
// - 32-bit ALU ops fully pipelined
// - single: sign, 8-bit exp bias 127
// - double: sign, 11-bit exp bias 1023
// - max exponent, zero fraction is infinity
// - zero exponent, zero fraction is zero
// - zero exponent, nonzero fraction is denormal
// - denormals wrap: shift, exponent one minus shifts
// - tiny results leave unrounded, wrapped exponent
// - made NaN has sign 0, all ones
// - pipeline advance every N+1 cycles
// - partial product field sets stage 2 time
`timescale 1ns/1ps
`include "fpd_params.svh"
module fpd_device (
    input wire logic i_clk,
    input wire logic i_reset,
    fpd_if.dev bus,
    output logic o_busy,
    output fpd_pkg::num_class_t o_class_a,
    output fpd_pkg::num_class_t o_class_b
);
    import fpd_pkg::*;

    // ----------
    // input beats
    // ----------
    logic hi_pend_r;
    logic [31:0] a_hi_r;
    logic [31:0] b_hi_r;
    func_t func_hi_r;
    logic enter;
    logic [63:0] word_a;
    logic [63:0] word_b;
    op_t in_op;

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            hi_pend_r <= 1'b0;
            a_hi_r <= 32'h0;
            b_hi_r <= 32'h0;
            func_hi_r <= FN_DIV;
        end else if (bus.load && bus.dbl && !hi_pend_r) begin
            hi_pend_r <= 1'b1;
            a_hi_r <= bus.a_word;
            b_hi_r <= bus.b_word;
            func_hi_r <= bus.func;
        end else begin
            hi_pend_r <= 1'b0;
        end
    end

    // doubles enter on their second beat
    assign enter = (bus.load && !bus.dbl && !hi_pend_r) || hi_pend_r;
    assign word_a = hi_pend_r ? {a_hi_r, bus.a_word} : {32'h0, bus.a_word};
    assign word_b = hi_pend_r ? {b_hi_r, bus.b_word} : {32'h0, bus.b_word};

    // ----------
    // classification
    // ----------
    num_class_t cls_a;
    num_class_t cls_b;
    logic sgn_a;
    logic sgn_b;
    logic signed [13:0] exp_a;
    logic signed [13:0] exp_b;
    logic [52:0] man_a;
    logic [52:0] man_b;

    fp_classify u_cls_a (
        .i_word(word_a),
        .i_dbl(hi_pend_r),
        .o_class(cls_a),
        .o_sign(sgn_a),
        .o_exp(exp_a),
        .o_mant(man_a)
    );

    fp_classify u_cls_b (
        .i_word(word_b),
        .i_dbl(hi_pend_r),
        .o_class(cls_b),
        .o_sign(sgn_b),
        .o_exp(exp_b),
        .o_mant(man_b)
    );

    always_comb begin
        in_op.func = hi_pend_r ? func_hi_r : bus.func;
        in_op.dbl = hi_pend_r;
        in_op.a = word_a;
        in_op.b = word_b;
        in_op.ca = cls_a;
        in_op.cb = cls_b;
        in_op.sa = sgn_a;
        in_op.sb = sgn_b;
        in_op.ea = exp_a;
        in_op.eb = exp_b;
        in_op.ma = man_a;
        in_op.mb = man_b;
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_class_a <= NUM_ZERO;
            o_class_b <= NUM_ZERO;
        end else if (enter) begin
            o_class_a <= cls_a;
            o_class_b <= cls_b;
        end
    end

    // ----------
    // stage timing
    // ----------
    logic [7:0] pac_cyc;
    logic [7:0] acc_cyc;

    assign pac_cyc = {6'h00, bus.pipe_adv} + `ONE_CYCLE;
    assign acc_cyc = {6'h00, bus.pp_adv} + `ONE_CYCLE;

    function automatic logic [7:0] dur(input int k, input op_t o);
        logic [7:0] d;
        d = pac_cyc;
        if (k == `STG_PIPE2) begin
            if (o.func == FN_DIV) begin
                // uniform bit plays no part here
                d = 8'((o.dbl ? `DIV_S2_DOUBLE : `DIV_S2_SINGLE) * acc_cyc);
            end else if (o.func == FN_MUL) begin
                d = (o.dbl || bus.s2_uniform) ?
                    8'(`MUL_S2_WIDE * acc_cyc) : acc_cyc;
            end
        end else if (k == `STG_PIPE3 && o.func == FN_DIV) begin
            d = 8'(`DIV_S3_MULT * pac_cyc);
        end else if (k == `STG_OUT) begin
            d = `ONE_CYCLE;
            if (o.func == FN_DIV) begin
                d = o.dbl ? `DIV_EXTRA_DOUBLE : `DIV_EXTRA_SINGLE;
            end
        end
        return d;
    endfunction : dur

    // ----------
    // stage chain
    // ----------
    logic [`STG_LAST:0] v_r;
    logic [`STG_LAST:0] mv;
    logic [`STG_LAST:0] kill;
    logic [`STG_LAST:0] free;
    logic [`STG_LAST:0] src_in;
    op_t op_r [`STG_NUM];
    op_t src_op [`STG_NUM];
    logic [7:0] cnt_r [`STG_NUM];

    genvar k;
    generate
        for (k = 0; k < `STG_NUM; k++) begin : g_stage
            if (k == `STG_LAST) begin : g_tail
                assign free[k] = 1'b1;
            end else begin : g_body
                assign free[k] = !v_r[k + 1] || mv[k + 1];
            end
            if (k == `STG_PIPE1) begin : g_head
                assign src_in[k] = enter;
                assign src_op[k] = in_op;
            end else begin : g_link
                assign src_in[k] = mv[k - 1] && !kill[k - 1];
                assign src_op[k] = op_r[k - 1];
            end
            // past ready a divide is done, so a paced load must spare it
            assign kill[k] = enter && v_r[k] && k <= `STG_PIPE2 &&
                             op_r[k].func == FN_DIV;
            assign mv[k] = v_r[k] && cnt_r[k] == `ONE_CYCLE && free[k];

            always_ff @(posedge i_clk or posedge i_reset) begin
                if (i_reset) begin
                    v_r[k] <= 1'b0;
                    cnt_r[k] <= `ONE_CYCLE;
                    op_r[k] <= '0;
                end else if (src_in[k]) begin
                    v_r[k] <= 1'b1;
                    op_r[k] <= src_op[k];
                    cnt_r[k] <= dur(k, src_op[k]);
                end else if (mv[k] || kill[k]) begin
                    v_r[k] <= 1'b0;
                end else if (v_r[k] && cnt_r[k] != `ONE_CYCLE) begin
                    cnt_r[k] <= cnt_r[k] - `ONE_CYCLE;
                end
            end
        end
    endgenerate

    // one op per stage lets 32-bit ALU ops stream every P cycles
    assign bus.can_load = !v_r[`STG_PIPE1] || mv[`STG_PIPE1];

    // ----------
    // arithmetic
    // ----------
    function automatic logic [63:0] calc(input op_t o);
        logic [106:0] q;
        logic [105:0] p;
        logic [52:0] dvs;
        logic signed [13:0] e;
        logic signed [13:0] bias;
        logic signed [13:0] emax;
        logic [51:0] m;
        logic s;
        logic nan;
        logic infinity_value;
        logic zero;
        bias = o.dbl ? `BIAS_D : `BIAS_S;
        emax = o.dbl ? `EMAX_D : `EMAX_S;
        s = o.sa ^ o.sb;
        q = 107'h0;
        p = 106'h0;
        if (o.func == FN_ALU) begin
            return o.dbl ? o.a + o.b : {32'h0, o.a[31:0] + o.b[31:0]};
        end
        if (o.func == FN_DIV) begin
            nan = o.ca == NUM_NAN || o.cb == NUM_NAN ||
                  (o.ca == NUM_ZERO && o.cb == NUM_ZERO) ||
                  (o.ca == NUM_INFINITY && o.cb == NUM_INFINITY);
            infinity_value = o.cb == NUM_INFINITY || o.ca == NUM_ZERO;
            zero = o.cb == NUM_ZERO || o.ca == NUM_INFINITY;
            dvs = (o.ma == 53'h0) ? 53'h1 : o.ma;
            q = {o.mb, 54'h0} / {54'h0, dvs};
            e = o.eb - o.ea + bias;
            if (q[54]) begin
                m = q[53:2];
            end else begin
                m = q[52:1];
                e = e - 14'sh0001;
            end
        end else begin
            nan = o.ca == NUM_NAN || o.cb == NUM_NAN ||
                  (o.ca == NUM_ZERO && o.cb == NUM_INFINITY) ||
                  (o.ca == NUM_INFINITY && o.cb == NUM_ZERO);
            infinity_value = o.ca == NUM_INFINITY || o.cb == NUM_INFINITY;
            zero = o.ca == NUM_ZERO || o.cb == NUM_ZERO;
            p = o.ma * o.mb;
            e = o.ea + o.eb - bias;
            if (p[105]) begin
                m = p[104:53];
                e = e + 14'sh0001;
            end else begin
                m = p[103:52];
            end
        end
        if (nan) begin
            return o.dbl ? `NAN_D : `NAN_S;
        end
        if (infinity_value || (!zero && e >= emax)) begin
            m = 52'h0;
            e = emax;
        end else if (zero) begin
            m = 52'h0;
            e = 14'sh0000;
        end
        // tiny results keep the wrapped exponent
        return o.dbl ? {s, e[10:0], m} : {32'h0, s, e[7:0], m[51:29]};
    endfunction : calc

    // ----------
    // outputs
    // ----------
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            bus.ready <= 1'b0;
        end else begin
            // partial results move into pipe stage 3 on this edge
            bus.ready <= mv[`STG_PIPE2] && !kill[`STG_PIPE2] &&
                         op_r[`STG_PIPE2].func == FN_DIV;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            bus.result_valid <= 1'b0;
            bus.result <= 64'h0;
        end else begin
            bus.result_valid <= mv[`STG_OUT] && !kill[`STG_OUT];
            if (mv[`STG_OUT] && !kill[`STG_OUT]) begin
                bus.result <= calc(op_r[`STG_OUT]);
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_busy <= 1'b0;
        end else begin
            o_busy <= |(v_r & ~mv) || |src_in;
        end
    end

endmodule : fpd_device

// ### hw/fpd_host.sv
// host sequencer end of the link: loads operands and paces divides
`timescale 1ns/1ps
`include "fpd_params.svh"
module fpd_host (
    input wire logic i_clk,
    input wire logic i_reset,
    fpd_if.host bus,
    input wire logic i_start,
    input fpd_pkg::func_t i_func,
    input wire logic i_dbl,
    input wire logic [63:0] i_a,
    input wire logic [63:0] i_b,
    input wire logic [1:0] i_pipe_adv,
    input wire logic [1:0] i_pp_adv,
    input wire logic i_uniform,
    input wire logic i_slow_grade,
    output logic o_busy,
    output logic o_result_valid,
    output logic [63:0] o_result
);
    import fpd_pkg::*;

    // ----------
    // sequencer
    // ----------
    host_state_t state_r;
    host_state_t state_nxt;
    logic [31:0] a_lo_r;
    logic [31:0] b_lo_r;
    logic div_r;
    logic [2:0] gap_r;
    logic [2:0] gap_len;
    logic take;

    assign take = i_start && bus.can_load;
    assign gap_len = i_slow_grade ? `GAP_SLOW : `GAP_FAST;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            H_IDLE: begin
                if (take) begin
                    state_nxt = i_dbl ? H_LO :
                                (i_func == FN_DIV) ? H_WAIT_RDY : H_IDLE;
                end
            end
            H_LO: begin
                state_nxt = div_r ? H_WAIT_RDY : H_IDLE;
            end
            H_WAIT_RDY: begin
                // paced by the pulse, not a fixed count
                if (bus.ready) begin
                    state_nxt = (gap_len == `GAP_FAST) ? H_IDLE : H_GAP;
                end
            end
            H_GAP: begin
                if (gap_r == 3'h0) begin
                    state_nxt = H_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_r <= H_IDLE;
            gap_r <= 3'h0;
        end else begin
            state_r <= state_nxt;
            if (state_r == H_WAIT_RDY && bus.ready) begin
                gap_r <= gap_len - `GAP_SHORT_OFF;
            end else if (state_r == H_GAP) begin
                gap_r <= gap_r - 3'h1;
            end
        end
    end

    // ----------
    // link drive
    // ----------
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            bus.load <= 1'b0;
            bus.func <= FN_DIV;
            bus.dbl <= 1'b0;
            bus.a_word <= 32'h0;
            bus.b_word <= 32'h0;
            a_lo_r <= 32'h0;
            b_lo_r <= 32'h0;
            div_r <= 1'b0;
        end else if (state_r == H_IDLE && take) begin
            bus.load <= 1'b1;
            bus.func <= i_func;
            bus.dbl <= i_dbl;
            bus.a_word <= i_dbl ? i_a[63:32] : i_a[31:0];
            bus.b_word <= i_dbl ? i_b[63:32] : i_b[31:0];
            a_lo_r <= i_a[31:0];
            b_lo_r <= i_b[31:0];
            div_r <= i_func == FN_DIV;
        end else if (state_r == H_LO) begin
            bus.load <= 1'b0;
            bus.a_word <= a_lo_r;
            bus.b_word <= b_lo_r;
        end else begin
            bus.load <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            bus.pipe_adv <= 2'h0;
            bus.pp_adv <= 2'h0;
            bus.s2_uniform <= 1'b0;
        end else if (state_r == H_IDLE && take) begin
            // fast grades run ALU ops at one cycle per stage
            bus.pipe_adv <= (i_func == FN_ALU && !i_slow_grade) ?
                            `ALU_OFF : i_pipe_adv;
            bus.pp_adv <= i_pp_adv;
            bus.s2_uniform <= i_uniform;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_busy <= 1'b0;
            o_result_valid <= 1'b0;
            o_result <= 64'h0;
        end else begin
            o_busy <= state_nxt != H_IDLE;
            o_result_valid <= bus.result_valid;
            if (bus.result_valid) begin
                o_result <= bus.result;
            end
        end
    end

endmodule : fpd_host

// ### test/fpd_link_sva.sv
// concurrent checks on the link between host and divide sequencer
`timescale 1ns/1ps
module fpd_link_sva (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic load,
    input fpd_pkg::func_t func,
    input wire logic dbl,
    input wire logic [1:0] pipe_adv,
    input wire logic [1:0] pp_adv,
    input wire logic ready,
    input wire logic result_valid,
    input wire logic [63:0] result
);
    import fpd_pkg::*;
    // ----------
    // divide tracking
    // ----------
    logic div_on_r;
    logic [7:0] cnt_r;
    logic [7:0] rdy_at_r;
    logic [1:0] p_r;
    logic dbl_r;
    logic [7:0] tail_r;
    logic [7:0] div_span;
    // divides ignore the uniform bit
    assign div_span = (8'(pp_adv) + 8'h01) * (dbl ? 8'h12 : 8'h09);
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            div_on_r <= 1'b0;
            cnt_r <= 8'h00;
            rdy_at_r <= 8'h00;
            p_r <= 2'h0;
            dbl_r <= 1'b0;
        end else if (load) begin
            div_on_r <= (func == FN_DIV);
            cnt_r <= 8'h01;
            rdy_at_r <= 8'(pipe_adv) + 8'h02 + 8'(dbl) + div_span;
            p_r <= pipe_adv;
            dbl_r <= dbl;
        end else if (ready) begin
            div_on_r <= 1'b0;
        end else if (div_on_r) begin
            cnt_r <= cnt_r + 8'h01;
        end
    end
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            tail_r <= 8'h00;
        end else if (ready) begin
            tail_r <= {5'h00, p_r, 1'b0} + 8'h03 + 8'(dbl_r);
        end else if (tail_r != 8'h00) begin
            tail_r <= tail_r - 8'h01;
        end
    end
    // ----------
    // properties
    // ----------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);
    sequence s_ready_due;
        div_on_r && cnt_r == rdy_at_r;
    endsequence
    sequence s_high_beat;
        load && dbl;
    endsequence
    a_ready_when_due: assert property (s_ready_due |-> ready)
        else $error("ready missing");
    a_ready_only_due: assert property (ready |-> s_ready_due)
        else $error("stray ready");
    a_ready_one_cycle: assert property (ready |=> !ready)
        else $error("ready longer than one cycle");
    a_div_latency: assert property (tail_r == 8'h01 |-> result_valid)
        else $error("divide result not on time");
    a_gap_after_ready: assert property (ready |=> !load)
        else $error("load right after ready");
    a_double_two_beats: assert property (s_high_beat |=> !load)
        else $error("double low beat carried a load");
    a_result_held: assert property (!result_valid |-> $stable(result))
        else $error("result moved");
    a_modes_held: assert property (div_on_r |-> $stable(pipe_adv)
        && $stable(pp_adv)) else $error("modes moved");
endmodule : fpd_link_sva

// ### test/fp_divide_timing_and_formats_bench.sv
// self-checking bench for the host and divide sequencer pair
`timescale 1ns/1ps
`include "fpd_params.svh"
module fp_divide_timing_and_formats_bench;
    import fpd_pkg::*;
    localparam logic [63:0] TWO_S = 64'h4000_0000;
    localparam logic [63:0] THREE_S = 64'h4040_0000;
    localparam logic [63:0] SIX_S = 64'h40C0_0000;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic i_start = 1'b0;
    func_t i_func = FN_DIV;
    logic i_dbl = 1'b0;
    logic [63:0] i_a = 64'h0;
    logic [63:0] i_b = 64'h0;
    logic [1:0] i_pipe_adv = 2'h0;
    logic [1:0] i_pp_adv = 2'h0;
    logic i_uniform = 1'b0;
    logic i_slow_grade = 1'b0;
    logic dev_busy;
    logic host_busy;
    num_class_t class_a;
    num_class_t class_b;
    logic o_result_valid;
    logic [63:0] o_result;
    int failures = 0;
    int n_tests = 0;
    always #2.5 i_clk = ~i_clk;
    fpd_if fpd_if_inst ();
    fpd_device fpd_device_inst (.i_clk, .i_reset, .bus(fpd_if_inst),
        .o_busy(dev_busy), .o_class_a(class_a), .o_class_b(class_b));
    fpd_host fpd_host_inst (.i_clk, .i_reset, .bus(fpd_if_inst), .i_start,
        .i_func, .i_dbl, .i_a, .i_b, .i_pipe_adv, .i_pp_adv, .i_uniform,
        .i_slow_grade, .o_busy(host_busy), .o_result_valid, .o_result);
    fpd_link_sva fpd_link_sva_inst (.i_clk, .i_reset,
        .load(fpd_if_inst.load), .func(fpd_if_inst.func),
        .dbl(fpd_if_inst.dbl), .pipe_adv(fpd_if_inst.pipe_adv),
        .pp_adv(fpd_if_inst.pp_adv), .ready(fpd_if_inst.ready),
        .result_valid(fpd_if_inst.result_valid),
        .result(fpd_if_inst.result));
    // ----------
    // shared tasks
    // ----------
    task automatic check(input string name, input logic [63:0] seen,
                         input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : check
    task automatic final_report;
        $display("comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report
    task automatic set_op(input func_t f, input logic d, input logic [63:0] a,
        input logic [63:0] b, input logic [1:0] pa, input logic [1:0] pp,
        input logic u);
        i_func <= f;
        i_dbl <= d;
        i_a <= a;
        i_b <= b;
        i_pipe_adv <= pa;
        i_pp_adv <= pp;
        i_uniform <= u;
        i_start <= 1'b1;
    endtask : set_op
    // lat counts cycles from the edge that raises start to the result pulse
    task automatic run_op(input func_t f, input logic d, input logic [63:0] a,
        input logic [63:0] b, input logic [1:0] pa, input logic [1:0] pp,
        input logic u, output logic [63:0] res, output int lat);
        @(posedge i_clk);
        set_op(f, d, a, b, pa, pp, u);
        @(posedge i_clk);
        i_start <= 1'b0;
        for (lat = 1; lat < 300; lat++) begin
            #1;
            if (o_result_valid === 1'b1) break;
            @(posedge i_clk);
        end
        res = o_result;
        check("idle", 64'({dev_busy, host_busy}), 64'h0);
    endtask : run_op
    // ----------
    // scenarios
    // ----------
    task automatic t_div_timing;
        logic [63:0] r;
        int n;
        run_op(FN_DIV, 1'b0, TWO_S, SIX_S, 2'h0, 2'h0, 1'b0, r, n);
        check("single quotient", r, THREE_S);
        check("single latency", 64'(n), 64'h10);
        run_op(FN_DIV, 1'b0, TWO_S, SIX_S, 2'h1, 2'h1, 1'b1, r, n);
        check("paced latency", 64'(n), 64'h1C);
        run_op(FN_DIV, 1'b1, 64'h4000_0000_0000_0000,
               64'h4018_0000_0000_0000, 2'h0, 2'h0, 1'b0, r, n);
        check("double quotient", r, 64'h4008_0000_0000_0000);
        check("double latency", 64'(n), 64'h1B);
        run_op(FN_DIV, 1'b0, 64'h0, 64'h0, 2'h0, 2'h0, 1'b0, r, n);
        check("made nan", r, `NAN_S);
    endtask : t_div_timing
    task automatic t_ready_gap(input logic slow, input int gap);
        int k;
        int r;
        int nres;
        @(posedge i_clk);
        i_slow_grade <= slow;
        set_op(FN_DIV, 1'b0, TWO_S, SIX_S, 2'h0, 2'h0, 1'b0);
        @(posedge i_clk);
        i_start <= 1'b0;
        for (k = 0; k < 100; k++) begin
            #1;
            if (fpd_if_inst.ready === 1'b1) break;
            @(posedge i_clk);
        end
        // start is held from the first cycle after ready until the cycle the grade allows a load
        nres = 0;
        r = 0;
        for (k = 1; k < 16; k++) begin
            @(posedge i_clk);
            if (k == 1) set_op(FN_MUL, 1'b0, TWO_S, THREE_S, 2'h0, 2'h0, 1'b0);
            if (k == gap) i_start <= 1'b0;
            #1;
            if (fpd_if_inst.load === 1'b1) r = k;
            if (o_result_valid === 1'b1) begin
                check("paced result", o_result, nres == 0 ? THREE_S : SIX_S);
                nres++;
            end
        end
        check("load gap", 64'(r), 64'(gap));
        check("results", 64'(nres), 64'h2);
    endtask : t_ready_gap
    task automatic t_alu;
        logic [63:0] r;
        int n;
        @(posedge i_clk);
        i_slow_grade <= 1'b0;
        run_op(FN_ALU, 1'b0, 64'h5, 64'h7, 2'h3, 2'h0, 1'b0, r, n);
        check("alu sum", r, 64'hC);
        check("alu latency", 64'(n), 64'h7);
        run_op(FN_ALU, 1'b1, 64'h0000_0001_FFFF_FFFF, 64'h1, 2'h3, 2'h0,
               1'b0, r, n);
        check("wide sum", r, 64'h0000_0002_0000_0000);
        check("wide latency", 64'(n), 64'h8);
    endtask : t_alu
    task automatic t_classes;
        logic [63:0] w [7] = '{64'h7FC0_0000, 64'hFF80_0000, 64'h0080_0000,
            64'h7F7F_FFFF, 64'h007F_FFFF, 64'h8000_0000, 64'h3F80_0000};
        num_class_t c [7] = '{NUM_NAN, NUM_INFINITY, NUM_NORMAL, NUM_NORMAL,
            NUM_DENORMAL, NUM_ZERO, NUM_NORMAL};
        logic [63:0] r;
        int n;
        for (int i = 0; i < 7; i++) begin
            run_op(FN_MUL, 1'b0, w[i], w[(i + 1) % 7], 2'h0, 2'h0, 1'b0, r, n);
            check("class a", 64'(class_a), 64'(c[i]));
            check("class b", 64'(class_b), 64'(c[(i + 1) % 7]));
        end
        run_op(FN_MUL, 1'b1, 64'h7FF0_0000_0000_0000, 64'h8000_0000_0000_0000,
               2'h0, 2'h0, 1'b0, r, n);
        check("double inf", 64'(class_a), 64'(NUM_INFINITY));
        check("double zero", 64'(class_b), 64'(NUM_ZERO));
        check("double nan", r, `NAN_D);
    endtask : t_classes
    // ----------
    // sequence and watchdog
    // ----------
    initial begin
        repeat (10) @(posedge i_clk);
        i_reset <= 1'b0;
        t_div_timing;
        t_ready_gap(1'b0, 2);
        t_ready_gap(1'b1, 4);
        t_alu;
        t_classes;
        final_report;
    end
    // the whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge i_clk);
        failures++;
        final_report;
    end
endmodule : fp_divide_timing_and_formats_bench
